// ===== rtl/cfg_hdr_map.svh
`ifndef CFG_HDR_MAP_SVH
`define CFG_HDR_MAP_SVH
// How it works
// - Maker identifier at offset 0 reads a fixed code; writes ignored.
// - Part identifier at offset 2 reads a fixed code; writes ignored.
// - Each function owns a command register at offset 4, reset zero.
// - Error enables ORed across functions; each copy stays readable.
// - Command bits 15 to 10 read zero; writes do nothing.
// - Command bit 9 reads zero; no fast back-to-back mastering.
// - System-error driver enabled only while command bit 8 is set.
// - Address parity errors raise system error only with bits 8 and 6.
// - Command bit 7 reads zero; no address or data stepping.
// - Bit 6 clear still sets status bit 15 on parity errors; set also reports data parity errors on the PERR pin.
// - Command bit 5 reads zero; palette accesses never snooped.
// - Command bit 4 reads zero; mastered writes use plain memory write.
// - Command bit 3 reads zero; special cycles never answered.
// - Bus initiator requests only while command bit 2 is set.
// - Memory cycles claimed only while command bit 1 is set.
// - I/O cycles claimed only while command bit 0 is set.
// - Each function has a status register at offset 6, reset 0210h.
// - Writing one clears a status flag; zero leaves it; reads are clean.
// - Parity error status bit 15 is set in both functions' status registers.
// - Status bits 10 and 9 hardwired to medium select timing.
// - Status bit 4 reads one: capabilities list present.
`define CFG_OFS_MAKER   8'h00
`define CFG_OFS_PART    8'h02
`define CFG_OFS_CMD     8'h04
`define CFG_OFS_STS     8'h06
`define CMD_BIT_IO      0
`define CMD_BIT_MEM     1
`define CMD_BIT_MST     2
`define CMD_BIT_PAR     6
`define CMD_BIT_SERR    8
`define CMD_RESET       16'h0000
`define CMD_RW_MASK     16'h0147
`define STS_RESET       16'h0210
`define STS_HARD        16'h0210
`define STS_W1C_MASK    16'hf900
`define STS_BIT_PAR     15
`define STS_BIT_SERR    14
`define STS_BIT_MABT    13
`define STS_BIT_TABT_R  12
`define STS_BIT_TABT_S  11
`define STS_BIT_DPAR    8
`define MEM_WRITE_CODE  4'h7
`endif

// ===== rtl/cfg_hdr_pkg.sv
package cfg_hdr_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_DONE} cfg_state_e;
  typedef logic [15:0] half_t;
  typedef logic [1:0]  func_vec_t;
endpackage

// ===== rtl/func_ctrl_if.sv
`timescale 1ns/1ns
interface func_ctrl_if;
  logic [1:0]  cmd_wr;
  logic [15:0] cmd_wdata;
  logic [1:0]  cmd_be;
  logic [15:0] cmd0;
  logic [15:0] cmd1;
  logic        system_error_driver_enable_any;
  logic        parity_response_enable_any;
  modport bank (input cmd_wr, cmd_wdata, cmd_be,
                output cmd0, cmd1, system_error_driver_enable_any, parity_response_enable_any);
  modport ctl  (output cmd_wr, cmd_wdata, cmd_be,
                input cmd0, cmd1, system_error_driver_enable_any, parity_response_enable_any);
  modport err  (input system_error_driver_enable_any, parity_response_enable_any);
endinterface

// ===== rtl/cmd_reg_bank.sv
`timescale 1ns/1ns
`include "cfg_hdr_map.svh"
module cmd_reg_bank (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // Command access
  func_ctrl_if.bank  fc
);
  import cfg_hdr_pkg::*;

  // ----------------------------------------
  // Byte-lane write with hardwired zeros
  // ----------------------------------------
  function automatic half_t next_cmd(input half_t q, input half_t w,
                                     input logic [1:0] be);
    half_t m;
    m = {{8{be[1]}}, {8{be[0]}}} & `CMD_RW_MASK;
    return (q & ~m) | (w & m);
  endfunction

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fc.cmd0 <= `CMD_RESET;
    end else if (fc.cmd_wr[0]) begin
      fc.cmd0 <= next_cmd(fc.cmd0, fc.cmd_wdata, fc.cmd_be);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fc.cmd1 <= `CMD_RESET;
    end else if (fc.cmd_wr[1]) begin
      fc.cmd1 <= next_cmd(fc.cmd1, fc.cmd_wdata, fc.cmd_be);
    end
  end

  // Shared error hardware sees the OR of both copies
  assign fc.system_error_driver_enable_any = fc.cmd0[`CMD_BIT_SERR]
                        | fc.cmd1[`CMD_BIT_SERR];
  assign fc.parity_response_enable_any = fc.cmd0[`CMD_BIT_PAR] | fc.cmd1[`CMD_BIT_PAR];
endmodule

// ===== rtl/error_report.sv
`timescale 1ns/1ns
`include "cfg_hdr_map.svh"
module error_report (
  // Clock and reset
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  // Enables
  func_ctrl_if.err   fc,
  // Detected errors
  input  wire logic  addr_perr_i,
  input  wire logic  data_perr_i,
  // Pin drive
  output logic       serr_oe_o,
  output logic       perr_oe_o
);
  // ----------------------------------------
  // System error driver
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serr_oe_o <= 1'b0;
    end else begin
      serr_oe_o <= addr_perr_i & fc.system_error_driver_enable_any & fc.parity_response_enable_any;
    end
  end

  // ----------------------------------------
  // Data parity error driver
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      perr_oe_o <= 1'b0;
    end else begin
      perr_oe_o <= data_perr_i & fc.parity_response_enable_any;
    end
  end
endmodule

// ===== rtl/pci_cfg_id_command_status.sv
`timescale 1ns/1ns
`include "cfg_hdr_map.svh"
module pci_cfg_id_command_status #(
  // Identification codes, values arbitrary
  parameter logic [15:0] MAKER_ID = 16'h5a5a,
  parameter logic [15:0] PART_ID  = 16'ha5a5
) (
  // Clock and reset
  input  wire logic                    REF_CLK_I,
  input  wire logic                    ARST_N_I,
  // Configuration access
  input  wire logic                    CFG_REQ_I,
  input  wire logic                    CFG_WRITE_I,
  input  wire logic                    CFG_FUNC_I,
  input  wire logic [5:0]              CFG_DWORD_I,
  input  wire logic [3:0]              CFG_BE_I,
  input  wire logic [31:0]             CFG_WDATA_I,
  output logic                         CFG_READY_O,
  output logic                         CFG_DONE_O,
  output logic [31:0]                  CFG_RDATA_O,
  // Bus events from the interface logic
  input  wire logic                    ADDR_PERR_I,
  input  wire logic                    DATA_PERR_I,
  input  wire logic                    PERR_SEEN_I,
  input  wire cfg_hdr_pkg::func_vec_t  MASTER_ACTIVE_I,
  input  wire cfg_hdr_pkg::func_vec_t  MABORT_I,
  input  wire cfg_hdr_pkg::func_vec_t  TABORT_RCVD_I,
  input  wire cfg_hdr_pkg::func_vec_t  TABORT_SIG_I,
  // Master and target gating
  input  wire cfg_hdr_pkg::func_vec_t  MASTER_REQ_I,
  input  wire cfg_hdr_pkg::func_vec_t  MEM_HIT_I,
  input  wire cfg_hdr_pkg::func_vec_t  IO_HIT_I,
  output logic                         BUS_REQ_O,
  output cfg_hdr_pkg::func_vec_t       MEM_CLAIM_O,
  output cfg_hdr_pkg::func_vec_t       IO_CLAIM_O,
  output logic [3:0]                   MEM_WR_CMD_O,
  // Error pins, open drain style
  output logic                         SERR_N_O,
  output logic                         SERR_OE_O,
  output logic                         PERR_N_O,
  output logic                         PERR_OE_O
);
  import cfg_hdr_pkg::*;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic       rst_meta;
  logic       rst_n;

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  func_ctrl_if  fc ();
  cfg_state_e   state;
  cfg_state_e   next_state;
  half_t        sts [2];
  half_t        cmd [2];
  logic         take;
  logic         hit_id;
  logic         hit_cs;
  logic         serr_sent;
  func_vec_t    mst_en;
  func_vec_t    mem_en;
  func_vec_t    io_en;

  assign cmd[0] = fc.cmd0;
  assign cmd[1] = fc.cmd1;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic half_t lane_mask(input logic [1:0] be);
    return {{8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic half_t next_sts(input half_t q, input half_t set,
                                     input half_t clr);
    half_t k;
    k = q & `STS_W1C_MASK & ~clr;
    return k | (set & `STS_W1C_MASK) | `STS_HARD;
  endfunction

  // ----------------------------------------
  // Access sequencing
  // ----------------------------------------
  assign take        = CFG_REQ_I && (state == ST_IDLE);
  assign hit_id      = (CFG_DWORD_I == 6'(`CFG_OFS_MAKER >> 2));
  assign hit_cs      = (CFG_DWORD_I == 6'(`CFG_OFS_CMD >> 2));
  assign CFG_READY_O = (state == ST_IDLE);
  assign CFG_DONE_O  = (state == ST_DONE);

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Command register writes
  // ----------------------------------------
  always_comb begin
    fc.cmd_wr    = 2'b00;
    fc.cmd_wdata = CFG_WDATA_I[15:0];
    fc.cmd_be    = CFG_BE_I[1:0];
    if (take && CFG_WRITE_I && hit_cs) begin
      fc.cmd_wr = CFG_FUNC_I ? 2'b10 : 2'b01;
    end
  end

  cmd_reg_bank u_cmd_bank (
    .clk_i   (REF_CLK_I),
    .rst_n_i (rst_n),
    .fc      (fc.bank)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CFG_RDATA_O <= 32'h0000_0000;
    end else if (take) begin
      if (CFG_WRITE_I) begin
        CFG_RDATA_O <= 32'h0000_0000;
      end else if (hit_id) begin
        CFG_RDATA_O <= {PART_ID, MAKER_ID};
      end else if (hit_cs) begin
        CFG_RDATA_O <= {sts[CFG_FUNC_I], cmd[CFG_FUNC_I]};
      end else begin
        CFG_RDATA_O <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // Status flags per function
  // ----------------------------------------
  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sts[0] <= `STS_RESET;
      sts[1] <= `STS_RESET;
    end else begin
      for (int f = 0; f < 2; f++) begin
        half_t set;
        half_t clr;
        set = 16'h0000;
        clr = 16'h0000;
        set[`STS_BIT_PAR]    = ADDR_PERR_I | DATA_PERR_I;
        set[`STS_BIT_SERR]   = serr_sent & cmd[f][`CMD_BIT_SERR];
        set[`STS_BIT_MABT]   = MABORT_I[f];
        set[`STS_BIT_TABT_R] = TABORT_RCVD_I[f];
        set[`STS_BIT_TABT_S] = TABORT_SIG_I[f];
        set[`STS_BIT_DPAR]   = PERR_SEEN_I & MASTER_ACTIVE_I[f]
                               & cmd[f][`CMD_BIT_PAR];
        if (take && CFG_WRITE_I && hit_cs && (CFG_FUNC_I == f[0])) begin
          clr = CFG_WDATA_I[31:16] & lane_mask(CFG_BE_I[3:2]);
        end
        sts[f] <= next_sts(sts[f], set, clr);
      end
    end
  end

  // ----------------------------------------
  // Error signalling
  // ----------------------------------------
  error_report u_err (
    .clk_i       (REF_CLK_I),
    .rst_n_i     (rst_n),
    .fc          (fc.err),
    .addr_perr_i (ADDR_PERR_I),
    .data_perr_i (DATA_PERR_I),
    .serr_oe_o   (SERR_OE_O),
    .perr_oe_o   (PERR_OE_O)
  );

  assign serr_sent = SERR_OE_O;
  assign SERR_N_O  = 1'b0;
  assign PERR_N_O  = 1'b0;

  // ----------------------------------------
  // Master and decode gating
  // ----------------------------------------
  assign mst_en = {cmd[1][`CMD_BIT_MST], cmd[0][`CMD_BIT_MST]};
  assign mem_en = {cmd[1][`CMD_BIT_MEM], cmd[0][`CMD_BIT_MEM]};
  assign io_en  = {cmd[1][`CMD_BIT_IO], cmd[0][`CMD_BIT_IO]};

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      BUS_REQ_O <= 1'b0;
    end else begin
      BUS_REQ_O <= |(MASTER_REQ_I & mst_en);
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      MEM_CLAIM_O <= 2'b00;
      IO_CLAIM_O  <= 2'b00;
    end else begin
      MEM_CLAIM_O <= MEM_HIT_I & mem_en;
      IO_CLAIM_O  <= IO_HIT_I & io_en;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      MEM_WR_CMD_O <= `MEM_WRITE_CODE;
    end else begin
      MEM_WR_CMD_O <= `MEM_WRITE_CODE;
    end
  end
endmodule

// ===== verification/pci_cfg_id_command_status_properties.sv
`timescale 1ns/1ns
module cfg_hdr_checker #(
  parameter logic [15:0] MAKER_ID = 16'h5a5a,
  parameter logic [15:0] PART_ID  = 16'ha5a5
) (
  input wire logic                   REF_CLK_I,
  input wire logic                   ARST_N_I,
  input wire logic                   CFG_REQ_I,
  input wire logic                   CFG_WRITE_I,
  input wire logic [5:0]             CFG_DWORD_I,
  input wire logic                   CFG_READY_O,
  input wire logic                   CFG_DONE_O,
  input wire logic [31:0]            CFG_RDATA_O,
  input wire logic                   ADDR_PERR_I,
  input wire logic                   DATA_PERR_I,
  input wire cfg_hdr_pkg::func_vec_t MASTER_REQ_I,
  input wire cfg_hdr_pkg::func_vec_t MEM_HIT_I,
  input wire cfg_hdr_pkg::func_vec_t IO_HIT_I,
  input wire logic                   BUS_REQ_O,
  input wire cfg_hdr_pkg::func_vec_t MEM_CLAIM_O,
  input wire cfg_hdr_pkg::func_vec_t IO_CLAIM_O,
  input wire logic [3:0]             MEM_WR_CMD_O,
  input wire logic                   SERR_OE_O,
  input wire logic                   PERR_OE_O
);
  import cfg_hdr_pkg::*;
  // ------------------------------
  // Port relations
  // ------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_take; CFG_REQ_I && CFG_READY_O; endsequence
  sequence s_rd(d); s_take ##0 (!CFG_WRITE_I && CFG_DWORD_I == d);
  endsequence
  property p_done;
    s_take |=> CFG_DONE_O && !CFG_READY_O ##1 CFG_READY_O;
  endproperty
  property p_ids; s_rd(6'h00) |=> CFG_RDATA_O == {PART_ID, MAKER_ID};
  endproperty
  property p_cmd_fixed; s_rd(6'h01) |=> (CFG_RDATA_O & 32'h0000feb8) == 0;
  endproperty
  property p_sts_fixed;
    s_rd(6'h01) |=> (CFG_RDATA_O & 32'h06ff0000) == 32'h02100000;
  endproperty
  property p_wr_code; MEM_WR_CMD_O == 4'h7; endproperty
  property p_serr; SERR_OE_O |-> $past(ADDR_PERR_I); endproperty
  property p_perr; PERR_OE_O |-> $past(DATA_PERR_I); endproperty
  property p_breq; BUS_REQ_O |-> $past(|MASTER_REQ_I); endproperty
  property p_claim;
    ((MEM_CLAIM_O & ~$past(MEM_HIT_I)) | (IO_CLAIM_O & ~$past(IO_HIT_I)))
      == 2'b00;
  endproperty
  a_done: assert property (p_done) else $error("done timing wrong");
  a_ids: assert property (p_ids) else $error("id read wrong");
  a_cmd_fixed: assert property (p_cmd_fixed)
    else $error("fixed command bit set");
  a_sts_fixed: assert property (p_sts_fixed)
    else $error("fixed status bits wrong");
  a_wr_code: assert property (p_wr_code) else $error("write code");
  a_serr: assert property (p_serr) else $error("serr without cause");
  a_perr: assert property (p_perr) else $error("perr without cause");
  a_breq: assert property (p_breq) else $error("bus request");
  a_claim: assert property (p_claim) else $error("claim");
endmodule

bind pci_cfg_id_command_status cfg_hdr_checker #(
  .MAKER_ID(MAKER_ID), .PART_ID(PART_ID)) cfg_hdr_checker_inst (
  .REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .CFG_REQ_I(CFG_REQ_I),
  .CFG_WRITE_I(CFG_WRITE_I), .CFG_DWORD_I(CFG_DWORD_I),
  .CFG_READY_O(CFG_READY_O), .CFG_DONE_O(CFG_DONE_O),
  .CFG_RDATA_O(CFG_RDATA_O), .ADDR_PERR_I(ADDR_PERR_I),
  .DATA_PERR_I(DATA_PERR_I), .MASTER_REQ_I(MASTER_REQ_I),
  .MEM_HIT_I(MEM_HIT_I), .IO_HIT_I(IO_HIT_I), .BUS_REQ_O(BUS_REQ_O),
  .MEM_CLAIM_O(MEM_CLAIM_O), .IO_CLAIM_O(IO_CLAIM_O),
  .MEM_WR_CMD_O(MEM_WR_CMD_O), .SERR_OE_O(SERR_OE_O),
  .PERR_OE_O(PERR_OE_O));

// ===== verification/cfg_host_model.sv
`timescale 1ns/1ns
module cfg_host_model (
  // Clock
  input  wire logic        clk_i,
  // Request
  output logic             req_o,
  output logic             write_o,
  output logic             func_o,
  output logic [5:0]       dword_o,
  output logic [3:0]       be_o,
  output logic [31:0]      wdata_o,
  // Answer
  input  wire logic        ready_i,
  input  wire logic        done_i,
  input  wire logic [31:0] rdata_i
);
  // ------------------------------
  // Configuration cycles
  // ------------------------------
  initial begin
    {req_o, write_o, func_o, dword_o, be_o, wdata_o} = '0;
  end
  task automatic xfer(input logic w, input logic f, input logic [5:0] d,
                      input logic [3:0] b, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge clk_i) #1;
    req_o = 1'b1;
    write_o = w;
    func_o = f;
    dword_o = d;
    be_o = b;
    wdata_o = wd;
    while (ready_i !== 1'b1 && n < 16) begin
      @(posedge clk_i) #1;
      n++;
    end
    @(posedge clk_i) #1;
    ok = (done_i === 1'b1) && (n < 16);
    rd = rdata_i;
    req_o = 1'b0;
    wdata_o = ~wd;
  endtask
endmodule

// ===== verification/pci_cfg_id_command_status_bench.sv
`timescale 1ns/1ns
module pci_cfg_id_command_status_bench;
  import cfg_hdr_pkg::*;
  typedef struct {
    logic w; logic f; logic [5:0] d; logic [3:0] b;
    logic [31:0] wd; logic [31:0] e;
  } row_s;
  localparam logic [15:0] MK = 16'h3c3c; // arbitrary
  localparam logic [15:0] PT = 16'hc3c3; // arbitrary
  logic        clk, arst_n, req, wr, fn, rdy, done, ape, dpe, pseen;
  logic        breq, serr_oe, perr_oe, serr_n, perr_n;
  logic [5:0]  dw;
  logic [3:0]  be, wcmd;
  logic [31:0] wd, rd;
  func_vec_t   mact, mab, tar, tas, mreq, mhit, ihit, mcl, icl;
  int          n_errors = 0;
  int          n_checks = 0;
  row_s rows [13] = '{
    '{0, 0, 6'h01, 4'h0, 0, 32'h02100000},
    '{0, 1, 6'h01, 4'h0, 0, 32'h02100000},
    '{0, 0, 6'h00, 4'h0, 0, {PT, MK}},
    '{1, 1, 6'h00, 4'hf, 32'hffffffff, 0},
    '{0, 1, 6'h00, 4'h0, 0, {PT, MK}},
    '{1, 0, 6'h01, 4'h3, 32'h0000ffff, 0},
    '{0, 0, 6'h01, 4'h0, 0, 32'h02100147},
    '{0, 1, 6'h01, 4'h0, 0, 32'h02100000},
    '{1, 1, 6'h01, 4'h1, 32'h00000040, 0},
    '{0, 1, 6'h01, 4'h0, 0, 32'h02100040},
    '{1, 0, 6'h01, 4'h2, 32'h00000000, 0},
    '{0, 0, 6'h01, 4'h0, 0, 32'h02100047},
    '{0, 0, 6'h05, 4'h0, 0, 32'h00000000}};
  pci_cfg_id_command_status #(.MAKER_ID(MK), .PART_ID(PT))
    pci_cfg_id_command_status_inst (
    .REF_CLK_I(clk), .ARST_N_I(arst_n), .CFG_REQ_I(req), .CFG_WRITE_I(wr),
    .CFG_FUNC_I(fn), .CFG_DWORD_I(dw), .CFG_BE_I(be), .CFG_WDATA_I(wd),
    .CFG_READY_O(rdy), .CFG_DONE_O(done), .CFG_RDATA_O(rd),
    .ADDR_PERR_I(ape), .DATA_PERR_I(dpe), .PERR_SEEN_I(pseen),
    .MASTER_ACTIVE_I(mact), .MABORT_I(mab), .TABORT_RCVD_I(tar),
    .TABORT_SIG_I(tas), .MASTER_REQ_I(mreq), .MEM_HIT_I(mhit),
    .IO_HIT_I(ihit), .BUS_REQ_O(breq), .MEM_CLAIM_O(mcl), .IO_CLAIM_O(icl),
    .MEM_WR_CMD_O(wcmd), .SERR_N_O(serr_n), .SERR_OE_O(serr_oe),
    .PERR_N_O(perr_n), .PERR_OE_O(perr_oe));
  cfg_host_model cfg_host_model_inst (
    .clk_i(clk), .req_o(req), .write_o(wr), .func_o(fn), .dword_o(dw),
    .be_o(be), .wdata_o(wd), .ready_i(rdy), .done_i(done), .rdata_i(rd));
  // ------------------------------
  // Tasks
  // ------------------------------
  task results;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task acc(input row_s r);
    logic [31:0] got;
    logic        ok;
    cfg_host_model_inst.xfer(r.w, r.f, r.d, r.b, r.wd, got, ok);
    if (ok !== 1'b1) begin
      n_errors++;
      results();
    end else if (!r.w) begin
      chk(got, r.e);
    end
  endtask
  task rst;
    @(posedge clk) #1;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    {arst_n, ape, dpe, pseen} = '0;
    {mact, mab, tar, tas, mreq, mhit, ihit} = '0;
    rst();
    foreach (rows[i]) acc(rows[i]);
    $display("test table done");
    @(posedge clk) #1;
    {mreq, mhit, ihit} = {2'b10, 2'b11, 2'b11};
    @(posedge clk) #1;
    chk(breq, 0);
    chk(mcl, 2'b01);
    chk(icl, 2'b01);
    mreq = 2'b01;
    @(posedge clk) #1;
    chk(breq, 1);
    $display("test gating done");
    {ape, dpe, mab, tar, tas, pseen, mact} = {2'b11, 6'b011001, 3'b101};
    @(posedge clk) #1;
    {ape, dpe, mab, tar, tas, pseen, mact} = '0;
    chk(serr_oe, 0);
    chk(perr_oe, 1);
    acc('{1, 1, 6'h01, 4'h2, 32'h00000100, 0});
    @(posedge clk) #1;
    ape = 1'b1;
    @(posedge clk) #1;
    ape = 1'b0;
    chk(serr_oe, 1);
    chk(serr_n, 0);
    chk(perr_n, 0);
    acc('{0, 0, 6'h01, 4'h0, 0, 32'hab100047});
    acc('{0, 1, 6'h01, 4'h0, 0, 32'hd2100140});
    acc('{1, 0, 6'h01, 4'h8, 32'h20000000, 0});
    acc('{0, 0, 6'h01, 4'h0, 0, 32'h8b100047});
    acc('{1, 0, 6'h01, 4'hc, 32'hffff0000, 0});
    acc('{0, 0, 6'h01, 4'h0, 0, 32'h02100047});
    $display("test status done");
    rst();
    acc('{0, 1, 6'h01, 4'h0, 0, 32'h02100000});
    chk(breq, 0);
    acc('{1, 0, 6'h01, 4'h2, 32'h00000100, 0});
    @(posedge clk) #1;
    {ape, dpe} = 2'b11;
    @(posedge clk) #1;
    {ape, dpe} = 2'b00;
    chk(serr_oe, 0);
    chk(perr_oe, 0);
    acc('{0, 0, 6'h01, 4'h0, 0, 32'h82100100});
    $display("test reset done");
    results();
  end
endmodule
